/* include/dcc_params.svh */
// Constants for the converter configuration control block.
`ifndef DCC_PARAMS_SVH
`define DCC_PARAMS_SVH

`define DCC_CFG_RESET    16'h0800
`define DCC_BIT_RDSRC    15
`define DCC_BIT_UPD      14
`define DCC_BIT_RST      13
`define DCC_BIT_PWRDN_A  12
`define DCC_BIT_PWRDN_B  11
`define DCC_BIT_CORR_EN  10
`define DCC_BIT_RSVD     9
`define DCC_BIT_SPANA    8
`define DCC_BIT_SPANB    7
`define DCC_GAIN_RESET   12'h800
`define DCC_ZERO_RESET   12'h000
`define DCC_DATA_RESET   12'h000
`define DCC_TRIM_SPAN6X  12'h99a
`define DCC_TRIM_SPAN4X  12'h800
`define DCC_GAIN_SHIFT   11

`endif

/* include/dcc_pkg.sv */
// Types shared by the converter configuration control block.
package dcc_pkg;

  typedef enum logic {
    DCC_RB_INPUT,
    DCC_RB_DAC
  } dcc_rb_src_t;

  typedef enum logic {
    DCC_SPAN_6X,
    DCC_SPAN_4X
  } dcc_span_t;

endpackage

/* verilog/dcc_config_ctrl.sv */
// Configuration register, correction engine and latch update control of an eight-channel converter.
`timescale 1ns/1ps
`default_nettype none
`include "dcc_params.svh"

// What this block does
// RULE1: After reset the configuration register reads 0x0800, readback select clear, group B power-down set.
// RULE2: Readback select picks input data (0) or corrected DAC data (1) on channel reads.
// RULE3: With correction on, input register keeps the raw word, DAC register the result.
// RULE4: Update bit with load pin high copies eligible DAC data into latches after correction.
// RULE5: Update reloads only channels written since the last load or update.
// RULE6: The update bit clears itself once the latch update is done.
// RULE7: With correction off, the update acts at once after the data write.
// RULE8: While the load pin is low, writes of the update bit are ignored.
// RULE9: Software reset bit resets like hardware reset and reads zero afterwards.
// RULE10: Group A power-down bit powers down channels 0 to 3; clearing restores them.
// RULE11: Group B power-down bit powers down channels 4 to 7; clearing restores them.
// RULE12: Correction on: word scaled by gain, plus zero, stored in DAC register.
// RULE13: Correction off: input word copied unchanged into DAC register at once.
// RULE14: The reserved configuration bit ignores writes and reads zero.
// RULE15: Group A span bit: zero selects six times reference, one four times.
// RULE16: A change of the group A span reloads the group A offset trim.
// RULE17: Group B span bit: zero selects six times reference, one four times.
// RULE18: A change of the group B span reloads the group B offset trim.
// RULE19: Don't-care bits ignore writes and read zero.
// RULE20: A write with a command bit also stores every other field; command reads zero later.
module dcc_config_ctrl #(
  parameter int N_CH = 8,
  parameter int DW   = 12
) (
  // Clock, reset and enable.
  input  wire logic                 CLK,
  input  wire logic                 RESETN,
  input  wire logic                 CE,
  // Configuration register access from the serial front end.
  input  wire logic                 CFG_WR,
  input  wire logic [15:0]          CFG_WDATA,
  output logic      [15:0]          CFG_RDATA,
  // Channel input data writes.
  input  wire logic                 CH_WR,
  input  wire logic [2:0]           CH_SEL,
  input  wire logic [DW-1:0]        CH_WDATA,
  // Gain and zero register writes.
  input  wire logic                 GZ_WR,
  input  wire logic                 GZ_GAIN,
  input  wire logic [2:0]           GZ_SEL,
  input  wire logic [DW-1:0]        GZ_WDATA,
  // Channel readback.
  input  wire logic [2:0]           RD_SEL,
  output logic      [DW-1:0]        RD_DATA,
  // Asynchronous latch load pin.
  input  wire logic                 ASYNC_LATCH_LOAD_N,
  // Converter side controls.
  output logic      [N_CH*DW-1:0]   LATCH_DATA,
  output logic                      GROUP_A_POWERDOWN,
  output logic                      GROUP_B_POWERDOWN,
  output logic                      SPAN_A_X4,
  output logic                      SPAN_B_X4,
  output logic      [DW-1:0]        OFFSET_A,
  output logic      [DW-1:0]        OFFSET_B,
  output logic                      CORR_BUSY
);

  localparam logic [15:0]   CFG_RST = `DCC_CFG_RESET;
  localparam logic [DW-1:0] TRIM6   = `DCC_TRIM_SPAN6X;
  localparam logic [DW-1:0] TRIM4   = `DCC_TRIM_SPAN4X;
  localparam logic [DW-1:0] GAIN_RV = `DCC_GAIN_RESET;
  localparam logic [DW-1:0] ZERO_RV = `DCC_ZERO_RESET;
  localparam logic [DW-1:0] DATA_RV = `DCC_DATA_RESET;

  generate
    if (N_CH != 8 || DW != 12)
    begin : g_check
      $error("dcc_config_ctrl serves exactly eight 12-bit channels");
    end
  endgenerate

  // Reset synchroniser; the soft reset joins it after the release.
  logic [1:0] rst_sync_q;
  logic       soft_q;
  wire        rst_n     = rst_sync_q[1];
  wire        rst_all_n = rst_n & ~soft_q;

  always_ff @(posedge CLK or negedge RESETN)
  begin
    if (!RESETN)
      rst_sync_q <= 2'b00;
    else
      rst_sync_q <= {rst_sync_q[0], 1'b1};
  end

  // Load pin synchroniser, idle high.
  logic load_meta_n_q;
  logic load_sync_n_q;

  always_ff @(posedge CLK or negedge rst_all_n)
  begin
    if (!rst_all_n)
    begin
      load_meta_n_q <= 1'b1;
      load_sync_n_q <= 1'b1;
    end
    else if (CE)
    begin
      load_meta_n_q <= ASYNC_LATCH_LOAD_N;
      load_sync_n_q <= load_meta_n_q;
    end
  end

  // Configuration state.
  dcc_pkg::dcc_rb_src_t rdsrc_q;
  dcc_pkg::dcc_span_t   span_a_q;
  dcc_pkg::dcc_span_t   span_b_q;
  logic                 upd_q;
  logic                 pwrdn_a_q;
  logic                 pwrdn_b_q;
  logic                 corr_en_q;
  logic [DW-1:0]        off_a_q;
  logic [DW-1:0]        off_b_q;

  // Per-channel storage.
  logic [N_CH-1:0][DW-1:0] input_q;
  logic [N_CH-1:0][DW-1:0] dac_q;
  logic [N_CH-1:0][DW-1:0] latch_q;
  logic [N_CH-1:0][DW-1:0] gain_q;
  logic [N_CH-1:0][DW-1:0] zero_q;
  logic [N_CH-1:0]         dirty_q;
  logic [N_CH-1:0]         pend_q;
  logic [DW-1:0]           rd_q;

  // Command decode.
  wire soft_req = CE & CFG_WR & CFG_WDATA[`DCC_BIT_RST];
  wire upd_req  = CFG_WR & CFG_WDATA[`DCC_BIT_UPD] & load_sync_n_q; // [RULE8]
  wire upd_fire = upd_q & ~(|pend_q); // [RULE4] [RULE7]
  wire upd_d    = upd_req | (upd_q & ~upd_fire); // [RULE6]

  wire span_a_d = CFG_WR ? CFG_WDATA[`DCC_BIT_SPANA] : span_a_q;
  wire span_b_d = CFG_WR ? CFG_WDATA[`DCC_BIT_SPANB] : span_b_q;
  wire span_a_chg = span_a_d != span_a_q;
  wire span_b_chg = span_b_d != span_b_q;

  // The soft reset is a one-cycle pulse that holds the rest of the block in reset.
  always_ff @(posedge CLK or negedge rst_n)
  begin
    if (!rst_n)
      soft_q <= 1'b0;
    else
      soft_q <= soft_req & ~soft_q; // [RULE9]
  end

  always_ff @(posedge CLK or negedge rst_all_n)
  begin
    if (!rst_all_n)
    begin
      rdsrc_q  <= dcc_pkg::dcc_rb_src_t'(CFG_RST[`DCC_BIT_RDSRC]); // [RULE1]
      upd_q     <= CFG_RST[`DCC_BIT_UPD];
      pwrdn_a_q <= CFG_RST[`DCC_BIT_PWRDN_A];
      pwrdn_b_q <= CFG_RST[`DCC_BIT_PWRDN_B];
      corr_en_q <= CFG_RST[`DCC_BIT_CORR_EN];
      span_a_q <= dcc_pkg::dcc_span_t'(CFG_RST[`DCC_BIT_SPANA]);
      span_b_q <= dcc_pkg::dcc_span_t'(CFG_RST[`DCC_BIT_SPANB]);
      off_a_q  <= TRIM6;
      off_b_q  <= TRIM6;
    end
    else if (CE)
    begin
      if (CFG_WR)
      begin
        rdsrc_q <= dcc_pkg::dcc_rb_src_t'(CFG_WDATA[`DCC_BIT_RDSRC]); // [RULE20]
        pwrdn_a_q <= CFG_WDATA[`DCC_BIT_PWRDN_A]; // [RULE10]
        pwrdn_b_q <= CFG_WDATA[`DCC_BIT_PWRDN_B]; // [RULE11]
        corr_en_q <= CFG_WDATA[`DCC_BIT_CORR_EN];
      end
      span_a_q <= dcc_pkg::dcc_span_t'(span_a_d); // [RULE15]
      span_b_q <= dcc_pkg::dcc_span_t'(span_b_d); // [RULE17]
      if (span_a_chg)
        off_a_q <= span_a_d ? TRIM4 : TRIM6; // [RULE16]
      if (span_b_chg)
        off_b_q <= span_b_d ? TRIM4 : TRIM6; // [RULE18]
      upd_q <= upd_d;
    end
  end

  // Correction engine: one pending channel per cycle, lowest index first.
  logic [2:0] eng_sel;

  always_comb
  begin
    eng_sel = 3'h0;
    for (int k = N_CH - 1; k >= 0; k--)
    begin
      if (pend_q[k])
        eng_sel = 3'(k);
    end
  end

  wire                 eng_go  = |pend_q;
  wire [2*DW-1:0]      prod    = input_q[eng_sel] * gain_q[eng_sel];
  wire [DW:0]          scaled  = prod[2*DW-1:`DCC_GAIN_SHIFT];
  wire signed [DW+2:0] sum     = $signed({2'b00, scaled})
                               + $signed({{3{zero_q[eng_sel][DW-1]}}, zero_q[eng_sel]});
  // Results saturate rather than wrap so an over-range trim never folds the output.
  wire [DW-1:0]        corr    = sum[DW+2] ? DATA_RV
                               : (|sum[DW+1:DW]) ? {DW{1'b1}} : sum[DW-1:0]; // [RULE12]

  // Per-channel next values.
  logic [N_CH-1:0][DW-1:0] input_d;
  logic [N_CH-1:0][DW-1:0] dac_d;
  logic [N_CH-1:0][DW-1:0] latch_d;
  logic [N_CH-1:0][DW-1:0] gain_d;
  logic [N_CH-1:0][DW-1:0] zero_d;
  logic [N_CH-1:0]         dirty_d;
  logic [N_CH-1:0]         pend_d;
  logic [N_CH-1:0]         load;

  generate
    for (genvar i = 0; i < N_CH; i++)
    begin : g_ch
      wire ch_hit  = CH_WR & (CH_SEL == 3'(i));
      wire g_hit   = GZ_WR & GZ_GAIN & (GZ_SEL == 3'(i));
      wire z_hit   = GZ_WR & ~GZ_GAIN & (GZ_SEL == 3'(i));
      wire eng_hit = eng_go & (eng_sel == 3'(i));
      // A low load pin keeps loading written channels as soon as their data is ready.
      assign load[i]    = (upd_fire | ~load_sync_n_q) & dirty_q[i] & ~pend_q[i]; // [RULE4] [RULE5]
      assign input_d[i] = ch_hit ? CH_WDATA : input_q[i]; // [RULE3]
      assign dac_d[i]   = (ch_hit & ~corr_en_q) ? CH_WDATA // [RULE13]
                        : eng_hit ? corr : dac_q[i]; // [RULE3]
      assign pend_d[i]  = (ch_hit & corr_en_q) | (pend_q[i] & ~eng_hit);
      assign dirty_d[i] = ch_hit | (dirty_q[i] & ~load[i]); // [RULE5]
      assign latch_d[i] = load[i] ? dac_q[i] : latch_q[i];
      assign gain_d[i]  = g_hit ? GZ_WDATA : gain_q[i];
      assign zero_d[i]  = z_hit ? GZ_WDATA : zero_q[i];
    end
  endgenerate

  always_ff @(posedge CLK or negedge rst_all_n)
  begin
    if (!rst_all_n)
    begin
      input_q <= {N_CH{DATA_RV}};
      dac_q   <= {N_CH{DATA_RV}};
      latch_q <= {N_CH{DATA_RV}};
      gain_q  <= {N_CH{GAIN_RV}};
      zero_q  <= {N_CH{ZERO_RV}};
      dirty_q <= '0;
      pend_q  <= '0;
    end
    else if (CE)
    begin
      input_q <= input_d;
      dac_q   <= dac_d;
      latch_q <= latch_d;
      gain_q  <= gain_d;
      zero_q  <= zero_d;
      dirty_q <= dirty_d;
      pend_q  <= pend_d;
    end
  end

  // Channel readback.
  wire [DW-1:0] rd_mux = (rdsrc_q == dcc_pkg::DCC_RB_DAC) ? dac_q[RD_SEL]
                                                           : input_q[RD_SEL]; // [RULE2]

  always_ff @(posedge CLK or negedge rst_all_n)
  begin
    if (!rst_all_n)
      rd_q <= DATA_RV;
    else if (CE)
      rd_q <= rd_mux;
  end

  // Reserved and don't-care bits are tied to zero.
  assign CFG_RDATA = {rdsrc_q, upd_q, soft_q, pwrdn_a_q, pwrdn_b_q, corr_en_q, 1'b0, // [RULE14]
                      span_a_q, span_b_q, 7'h00}; // [RULE19]

  assign RD_DATA           = rd_q;
  assign LATCH_DATA        = latch_q;
  assign GROUP_A_POWERDOWN = pwrdn_a_q;
  assign GROUP_B_POWERDOWN = pwrdn_b_q;
  assign SPAN_A_X4         = span_a_q;
  assign SPAN_B_X4         = span_b_q;
  assign OFFSET_A          = off_a_q;
  assign OFFSET_B          = off_b_q;
  assign CORR_BUSY         = eng_go;

  // Checks.
  property p_reset_value;
    @(posedge CLK) disable iff (!RESETN)
    $rose(rst_all_n) |-> CFG_RDATA == CFG_RST;
  endproperty
  a_reset_value: assert property (p_reset_value) else $error("reset value wrong"); // [RULE1]

  property p_readback;
    @(posedge CLK) disable iff (!rst_all_n)
    CE && rdsrc_q == dcc_pkg::DCC_RB_DAC ##1 CE |-> RD_DATA == $past(dac_q[RD_SEL]);
  endproperty
  a_readback: assert property (p_readback) else $error("readback source wrong"); // [RULE2]

  property p_raw_keep;
    @(posedge CLK) disable iff (!rst_all_n)
    CE && CH_WR && corr_en_q
      |=> input_q[$past(CH_SEL)] == $past(CH_WDATA) && pend_q[$past(CH_SEL)];
  endproperty
  a_raw_keep: assert property (p_raw_keep) else $error("raw word or pending lost"); // [RULE3]

  property p_direct_copy;
    @(posedge CLK) disable iff (!rst_all_n)
    CE && CH_WR && !corr_en_q |=> dac_q[$past(CH_SEL)] == $past(CH_WDATA);
  endproperty
  a_direct_copy: assert property (p_direct_copy) else $error("direct copy missing"); // [RULE13]

  property p_upd_ignored;
    @(posedge CLK) disable iff (!rst_all_n)
    CE && CFG_WR && CFG_WDATA[`DCC_BIT_UPD] && !load_sync_n_q && !upd_q |=> !upd_q;
  endproperty
  a_upd_ignored: assert property (p_upd_ignored) else $error("update taken with pin low"); // [RULE8]

  property p_upd_clears;
    @(posedge CLK) disable iff (!rst_all_n)
    CE && upd_q && pend_q == '0 && !upd_req
      |=> !upd_q && dirty_q == (N_CH'($past(CH_WR)) << $past(CH_SEL));
  endproperty
  a_upd_clears: assert property (p_upd_clears) else $error("update bit stuck"); // [RULE6]

  property p_only_dirty;
    @(posedge CLK) disable iff (!rst_all_n)
    CE && upd_fire && dirty_q[0] == 1'b0 |=> latch_q[0] == $past(latch_q[0]);
  endproperty
  a_only_dirty: assert property (p_only_dirty) else $error("clean latch reloaded"); // [RULE5]

  property p_span_a_trim;
    @(posedge CLK) disable iff (!rst_all_n)
    CE && span_a_chg |=> OFFSET_A == (SPAN_A_X4 ? TRIM4 : TRIM6) && SPAN_A_X4 != $past(SPAN_A_X4);
  endproperty
  a_span_a_trim: assert property (p_span_a_trim) else $error("offset A not reloaded"); // [RULE16]

  property p_span_b_trim;
    @(posedge CLK) disable iff (!rst_all_n)
    CE && span_b_chg |=> OFFSET_B == (SPAN_B_X4 ? TRIM4 : TRIM6) && SPAN_B_X4 != $past(SPAN_B_X4);
  endproperty
  a_span_b_trim: assert property (p_span_b_trim) else $error("offset B not reloaded"); // [RULE18]

  property p_soft_reset;
    @(posedge CLK) disable iff (!rst_n)
    soft_req && !soft_q |=> soft_q ##1 (!soft_q && CFG_RDATA == CFG_RST);
  endproperty
  a_soft_reset: assert property (p_soft_reset) else $error("soft reset wrong"); // [RULE9]

  property p_pwrdn_a;
    @(posedge CLK) disable iff (!rst_all_n)
    CE && CFG_WR |=> GROUP_A_POWERDOWN == $past(CFG_WDATA[`DCC_BIT_PWRDN_A]);
  endproperty
  a_pwrdn_a: assert property (p_pwrdn_a) else $error("group A power-down wrong"); // [RULE10]

  property p_pwrdn_b;
    @(posedge CLK) disable iff (!rst_all_n)
    CE && CFG_WR |=> GROUP_B_POWERDOWN == $past(CFG_WDATA[`DCC_BIT_PWRDN_B]);
  endproperty
  a_pwrdn_b: assert property (p_pwrdn_b) else $error("group B power-down wrong"); // [RULE11]

  property p_reserved;
    @(posedge CLK) disable iff (!rst_all_n)
    CE && CFG_WR |=> CFG_RDATA[`DCC_BIT_RSVD] == 1'b0 && CFG_RDATA[6:0] == 7'h00;
  endproperty
  a_reserved: assert property (p_reserved) else $error("reserved bits not zero"); // [RULE14]

endmodule
`default_nettype wire

/* tb/dcc_host_model.sv */
// Serial host stand-in that issues one-cycle configuration write strobes.
`timescale 1ns/1ps
`default_nettype none
module dcc_host_model (
  // Clock and reset.
  input  wire logic        clk,
  input  wire logic        rst_n,
  // Request from the bench.
  input  wire logic        go,
  input  wire logic [15:0] word,
  // Configuration write port.
  output logic             cfg_wr,
  output logic      [15:0] cfg_wdata
);
  // The strobe is held low through reset so no write lands before release.
  always_ff @(posedge clk or negedge rst_n)
  begin
    if (!rst_n)
    begin
      cfg_wr    <= 1'b0;
      cfg_wdata <= 16'h0000;
    end
    else
    begin
      cfg_wr    <= go;
      cfg_wdata <= go ? word : ~cfg_wdata;
    end
  end
endmodule
`default_nettype wire

/* tb/tb.sv */
// Self-checking bench for the converter configuration control block.
`timescale 1ns/1ps
`default_nettype none
`include "dcc_params.svh"
module tb;
  logic        clk = 0, rst_n = 0, ce = 1, go = 0, load_n = 1;
  logic [15:0] word = 0, cfg_wdata, cfg_rdata;
  logic        cfg_wr, ch_wr = 0, gz_wr = 0, gz_gain = 0, pwrdn_a, pwrdn_b, sa, sb, busy;
  logic [2:0]  ch_sel = 0, gz_sel = 0, rd_sel = 0;
  logic [11:0] ch_wdata = 0, gz_wdata = 0, rd_data, oa, ob, d;
  logic [95:0] latch, exp_lat;
  logic [11:0] cg [3], cz [3], cd [3];
  logic [2:0]  cc [3];
  int          n_fail = 0, checks = 0, cyc = 0, seed = 32'h6f13, k;
  always #2 clk = ~clk;
  dcc_host_model u_dcc_host_model (.clk(clk), .rst_n(rst_n), .go(go), .word(word),
    .cfg_wr(cfg_wr), .cfg_wdata(cfg_wdata));
  dcc_config_ctrl u_dcc_config_ctrl (.CLK(clk), .RESETN(rst_n), .CE(ce), .CFG_WR(cfg_wr),
    .CFG_WDATA(cfg_wdata), .CFG_RDATA(cfg_rdata), .CH_WR(ch_wr), .CH_SEL(ch_sel),
    .CH_WDATA(ch_wdata), .GZ_WR(gz_wr), .GZ_GAIN(gz_gain), .GZ_SEL(gz_sel),
    .GZ_WDATA(gz_wdata), .RD_SEL(rd_sel), .RD_DATA(rd_data), .ASYNC_LATCH_LOAD_N(load_n),
    .LATCH_DATA(latch), .GROUP_A_POWERDOWN(pwrdn_a), .GROUP_B_POWERDOWN(pwrdn_b),
    .SPAN_A_X4(sa), .SPAN_B_X4(sb), .OFFSET_A(oa), .OFFSET_B(ob), .CORR_BUSY(busy));
  task automatic conclude();
    if (n_fail == 0 && checks > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic chk(string name, logic [95:0] seen, logic [95:0] exp);
    checks++;
    if (seen !== exp)
    begin
      n_fail++;
      $display("wrong value %s expected %h seen %h", name, exp, seen);
    end
  endtask
  // Saturating gain and signed zero correction, clamped to the 12-bit code range.
  function automatic logic [11:0] corr(logic [11:0] x, logic [11:0] g, logic [11:0] z);
    logic [23:0]        p;
    logic signed [25:0] t;
    p = ({12'h000, x} * {12'h000, g}) >> 11;
    t = $signed({2'b00, p}) + $signed({{14{z[11]}}, z});
    if (t < 0)
      return 12'h000;
    if (t > 26'sd4095)
      return 12'hfff;
    return t[11:0];
  endfunction
  // Returns at the edge that takes the write, plus settling time.
  task automatic wr_cfg(logic [15:0] w);
    @(posedge clk);
    go   <= 1'b1;
    word <= w;
    @(posedge clk);
    go <= 1'b0;
    @(posedge clk);
    #1;
  endtask
  task automatic wr_ch(logic [2:0] s, logic [11:0] v);
    @(posedge clk);
    ch_wr    <= 1'b1;
    ch_sel   <= s;
    ch_wdata <= v;
    @(posedge clk);
    ch_wr <= 1'b0;
  endtask
  task automatic wr_gz(logic gain, logic [2:0] s, logic [11:0] v);
    @(posedge clk);
    gz_wr    <= 1'b1;
    gz_gain  <= gain;
    gz_sel   <= s;
    gz_wdata <= v;
    @(posedge clk);
    gz_wr <= 1'b0;
  endtask
  task automatic rd(logic [2:0] s, logic [11:0] exp);
    @(posedge clk);
    rd_sel <= s;
    @(posedge clk);
    #1;
    chk("rd_data", rd_data, exp);
  endtask
  always @(posedge clk)
  begin
    cyc++;
    if (cyc == 5000)
    begin
      n_fail++;
      conclude();
    end
  end
  initial
  begin
    exp_lat = '0;
    repeat (12) @(posedge clk);
    rst_n <= 1'b1;
    repeat (3) @(posedge clk);
    #1;
    chk("cfg", cfg_rdata, `DCC_CFG_RESET);
    chk("offsets", {oa, ob}, {2{`DCC_TRIM_SPAN6X}});
    wr_cfg(16'h9bff);
    chk("cfg", cfg_rdata, 16'h9980);
    chk("powerdown", {pwrdn_a, pwrdn_b}, 2'b11);
    chk("span", {sa, sb}, 2'b11);
    chk("offsets", {oa, ob}, {2{`DCC_TRIM_SPAN4X}});
    wr_cfg(16'h8000);
    chk("powerdown", {pwrdn_a, pwrdn_b, sa, sb}, 4'b0000);
    chk("offsets", {oa, ob}, {2{`DCC_TRIM_SPAN6X}});
    for (int i = 0; i < 8; i += 3)
    begin
      d = 12'($random(seed));
      wr_ch(i[2:0], d);
      exp_lat[12*i +: 12] = d;
      rd(i[2:0], d);
    end
    chk("latch", latch, 96'h0);
    wr_cfg(16'hc180);
    @(posedge clk);
    #1;
    chk("cfg", cfg_rdata, 16'h8180);
    chk("latch", latch, exp_lat);
    chk("offsets", {oa, ob}, {2{`DCC_TRIM_SPAN4X}});
    load_n <= 1'b0;
    repeat (4) @(posedge clk);
    d = 12'($random(seed));
    wr_ch(3'd4, d);
    exp_lat[48 +: 12] = d;
    wr_cfg(16'hc180);
    chk("update_bit", cfg_rdata[14], 1'b0);
    chk("latch", latch, exp_lat);
    load_n <= 1'b1;
    repeat (4) @(posedge clk);
    cc = '{3'd1, 3'd6, 3'd7};
    cg = '{12'($random(seed)), 12'($random(seed)), 12'hfff};
    cz = '{12'h800, 12'($random(seed)), 12'h7ff};
    cd = '{12'h010, 12'($random(seed)), 12'hfff};
    wr_cfg(16'h8400);
    for (int j = 0; j < 3; j++)
    begin
      wr_gz(1'b1, cc[j], cg[j]);
      wr_gz(1'b0, cc[j], cz[j]);
      wr_ch(cc[j], cd[j]);
      exp_lat[12*cc[j] +: 12] = corr(cd[j], cg[j], cz[j]);
    end
    #1;
    k = 0;
    while (busy !== 1'b0 && k < 20)
    begin
      @(posedge clk);
      #1;
      k++;
    end
    chk("busy", busy, 1'b0);
    for (int j = 0; j < 3; j++)
      rd(cc[j], corr(cd[j], cg[j], cz[j]));
    wr_cfg(16'hc400);
    @(posedge clk);
    #1;
    chk("latch", latch, exp_lat);
    wr_cfg(16'h0400);
    for (int j = 0; j < 3; j++)
      rd(cc[j], cd[j]);
    wr_cfg(16'h2000);
    repeat (2) @(posedge clk);
    #1;
    chk("cfg", cfg_rdata, `DCC_CFG_RESET);
    chk("latch", latch, 96'h0);
    chk("offsets", {oa, ob}, {2{`DCC_TRIM_SPAN6X}});
    rd(3'd7, 12'h000);
    // A write while the clock enable is low must leave every field untouched.
    @(posedge clk);
    ce <= 1'b0;
    wr_cfg(16'h9c00);
    chk("cfg_frozen", cfg_rdata, `DCC_CFG_RESET);
    ce <= 1'b1;
    // Channel 7 had a full-scale gain before the soft reset; the default gain must be back.
    wr_cfg(16'h8400);
    d = 12'($random(seed));
    wr_ch(3'd7, d);
    rd(3'd7, corr(d, `DCC_GAIN_RESET, `DCC_ZERO_RESET));
    conclude();
  end
endmodule
`default_nettype wire
